// ### rtl/rpr_defines.svh
// register indexes, field positions, reset values and timing counts
// assumes byte address = 4 * index on a 32-bit bus
`ifndef RPR_DEFINES_SVH
`define RPR_DEFINES_SVH

`define RPR_IDX_LINE_STATUS 8'h02
`define RPR_IDX_ERR_PEAK_LO 8'h18
`define RPR_IDX_ERR_PEAK_HI 8'h19
`define RPR_IDX_RX_GAIN     8'h20
`define RPR_IDX_OUT_PEAK_LO 8'h3A
`define RPR_IDX_IRQ_STATUS  8'h40
`define RPR_IDX_IRQ_MASK    8'h41

`define RPR_STATUS_RESET    8'h00
`define RPR_RX_GAIN_RESET   8'h6D
`define RPR_IRQ_MASK_RESET  4'h0
`define RPR_PEAK_RESET      16'h0000

`define RPR_BIT_NBR 0
`define RPR_BIT_NB  1
`define RPR_BIT_DT  2
`define RPR_BIT_NLP 3

`define RPR_GAIN_FRAC   12
`define RPR_CLK_MHZ     200
`define RPR_DECAY_US    1000
`define RPR_DECAY_CYCLES (`RPR_DECAY_US * `RPR_CLK_MHZ)
`define RPR_DECAY_SHIFT 4

`endif

// ### rtl/rpr_pkg.sv
// types and register decode shared by the register group
// assumes the defines header is on the include path
`include "rpr_defines.svh"

package rpr_pkg;

  typedef logic [7:0] rpr_byte_t;
  typedef logic [3:0] rpr_gain_code_t;

  typedef enum logic [2:0] {
    RPR_SEL_NONE,
    RPR_SEL_STATUS,
    RPR_SEL_ERR_LO,
    RPR_SEL_ERR_HI,
    RPR_SEL_GAIN,
    RPR_SEL_OUT_LO,
    RPR_SEL_IRQ_ST,
    RPR_SEL_IRQ_MASK
  } rpr_reg_sel_t;

  function automatic rpr_reg_sel_t rpr_decode(input rpr_byte_t idx);
    case (idx)
      `RPR_IDX_LINE_STATUS: rpr_decode = RPR_SEL_STATUS;
      `RPR_IDX_ERR_PEAK_LO: rpr_decode = RPR_SEL_ERR_LO;
      `RPR_IDX_ERR_PEAK_HI: rpr_decode = RPR_SEL_ERR_HI;
      `RPR_IDX_RX_GAIN:     rpr_decode = RPR_SEL_GAIN;
      `RPR_IDX_OUT_PEAK_LO: rpr_decode = RPR_SEL_OUT_LO;
      `RPR_IDX_IRQ_STATUS:  rpr_decode = RPR_SEL_IRQ_ST;
      `RPR_IDX_IRQ_MASK:    rpr_decode = RPR_SEL_IRQ_MASK;
      default:              rpr_decode = RPR_SEL_NONE;
    endcase
  endfunction : rpr_decode

endpackage : rpr_pkg

// ### rtl/rpr_gain_stage.sv
// receive user gain, -24 dB to +21 dB in 3 dB steps, saturating
// assumes samples are 16-bit two's complement, one per valid pulse
`timescale 1ns/1ps
`include "rpr_defines.svh"

module rpr_gain_stage
  import rpr_pkg::*;
(
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // gain and samples
  input  wire rpr_gain_code_t gain_code_i,
  input  wire logic [15:0]    sample_i,
  input  wire logic           valid_i,
  output logic [15:0]         sample_o,
  output logic                valid_o
);

  // linear gain, unsigned with 12 fraction bits
  function automatic logic [15:0] gain_mult(input rpr_gain_code_t code);
    case (code)
      4'h0: gain_mult = 16'h0102;
      4'h1: gain_mult = 16'h016D;
      4'h2: gain_mult = 16'h0204;
      4'h3: gain_mult = 16'h02D8;
      4'h4: gain_mult = 16'h0405;
      4'h5: gain_mult = 16'h05AD;
      4'h6: gain_mult = 16'h0805;
      4'h7: gain_mult = 16'h0B54;
      4'h8: gain_mult = 16'h1000;
      4'h9: gain_mult = 16'h169A;
      4'hA: gain_mult = 16'h1FED;
      4'hB: gain_mult = 16'h2D18;
      4'hC: gain_mult = 16'h3FB2;
      4'hD: gain_mult = 16'h59F9;
      4'hE: gain_mult = 16'h7F18;
      default: gain_mult = 16'hB386;
    endcase
  endfunction : gain_mult

  localparam int F = `RPR_GAIN_FRAC;

  logic signed [32:0] prod;
  logic               ovf;
  logic [15:0]        next_sample;

  assign prod = $signed(sample_i) * $signed({1'b0, gain_mult(gain_code_i)});
  assign ovf  = ~((&prod[32:F+15]) | ~(|prod[32:F+15]));
  assign next_sample = ovf ? (prod[32] ? 16'h8000 : 16'h7FFF) : prod[F+15:F];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_o <= 16'h0000;
      valid_o  <= 1'b0;
    end else begin
      valid_o <= valid_i;
      if (valid_i) begin
        sample_o <= next_sample;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_unity_gain;
    valid_i && gain_code_i == 4'h8 |=> valid_o && sample_o == $past(sample_i);
  endproperty
  a_unity_gain: assert property (p_unity_gain)
    else $error("code 8 does not pass the sample unchanged");

endmodule : rpr_gain_stage

// ### rtl/rpr_peak_track.sv
// peak magnitude tracker with slow decay
// assumes decay_i is a one-cycle enable pulse from a divider
`timescale 1ns/1ps
`include "rpr_defines.svh"

module rpr_peak_track #(
  parameter int unsigned W     = 16,
  parameter int unsigned SHIFT = `RPR_DECAY_SHIFT
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // samples and decay
  input  wire logic [W-1:0] sample_i,
  input  wire logic         valid_i,
  input  wire logic         decay_i,
  output logic [W-1:0]      peak_o
);

  logic [W-1:0] mag;
  logic         bigger;

  // magnitude, full negative clipped to the largest positive
  assign mag = ~sample_i[W-1] ? sample_i :
               (sample_i == {1'b1, {(W-1){1'b0}}}) ? {1'b0, {(W-1){1'b1}}} :
               (~sample_i + 1'b1);
  assign bigger = valid_i && (mag > peak_o);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peak_o <= `RPR_PEAK_RESET;
    end else if (bigger) begin
      peak_o <= mag;
    end else if (decay_i) begin
      peak_o <= peak_o - (peak_o >> SHIFT);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_peak_holds;
    !decay_i |=> peak_o >= $past(peak_o);
  endproperty
  a_peak_holds: assert property (p_peak_holds)
    else $error("peak fell without a decay tick");

endmodule : rpr_peak_track

// ### rtl/rpr_regs.sv
// ----------------------------------------------------------------
// receive path status, gain and peak register group
// ----------------------------------------------------------------
// holds line status flags, receive gain, peak readouts and interrupts
// assumes classic wishbone slave, detector flags synchronous to clk_i
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "rpr_defines.svh"

// What this block does
// - status bit 0 follows receive narrowband
// - status bit 1 is either narrowband flag
// - status bit 2 follows double talk
// - status bit 3 follows nonlinear processor
// - gain code scales receive path
// - gain register read/write, reset 6Dh
// - error peak tracked, read at 18h/19h
// - peak is 16-bit, low byte first
// - output peak low byte at 3Ah
// - send narrowband feeds combined flag
module rpr_regs
  import rpr_pkg::*;
#(
  parameter int unsigned DECAY_CYCLES = `RPR_DECAY_CYCLES,
  parameter int unsigned SAMPLE_W     = 16
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,

  // wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [9:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic [31:0]              dat_o,
  output logic                     ack_o,

  // detector flags
  input  wire logic                receive_narrowband_flag_i,
  input  wire logic                send_narrowband_flag_i,
  input  wire logic                double_talk_flag_i,
  input  wire logic                line_nonlinear_active_i,

  // receive samples
  input  wire logic [SAMPLE_W-1:0] rin_sample_i,
  input  wire logic                rin_valid_i,
  input  wire logic [SAMPLE_W-1:0] rerr_sample_i,
  input  wire logic                rerr_valid_i,
  output logic [SAMPLE_W-1:0]      rout_sample_o,
  output logic                     rout_valid_o,

  // interrupt
  output logic                     irq_o
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------

  logic         bus_req;
  logic         bus_wr;
  logic         bus_rd;
  rpr_reg_sel_t bus_sel;

  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign bus_wr  = bus_req & we_i;
  assign bus_rd  = bus_req & ~we_i;
  assign bus_sel = rpr_decode(adr_i[9:2]);

  // ----------------------------------------------------------------
  // line canceller status
  // ----------------------------------------------------------------

  logic [7:0] line_status;
  logic [7:0] next_line_status;
  logic       narrowband_any_flag;

  assign narrowband_any_flag = receive_narrowband_flag_i | send_narrowband_flag_i;

  assign next_line_status = {
    4'h0,
    line_nonlinear_active_i,
    double_talk_flag_i,
    narrowband_any_flag,
    receive_narrowband_flag_i
  };

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_status <= `RPR_STATUS_RESET;
    end else begin
      line_status <= next_line_status;
    end
  end

  // ----------------------------------------------------------------
  // receive gain setting
  // ----------------------------------------------------------------

  rpr_byte_t receive_gain_setting;
  logic      gain_wr;

  assign gain_wr = bus_wr & sel_i[0] & (bus_sel == RPR_SEL_GAIN);

  // gain code write, reserved bits kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_gain_setting <= `RPR_RX_GAIN_RESET;
    end else if (gain_wr) begin
      receive_gain_setting <= {receive_gain_setting[7:4], dat_i[3:0]};
    end
  end

  rpr_gain_stage u_gain (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .gain_code_i (receive_gain_setting[3:0]),
    .sample_i    (rin_sample_i),
    .valid_i     (rin_valid_i),
    .sample_o    (rout_sample_o),
    .valid_o     (rout_valid_o)
  );

  // ----------------------------------------------------------------
  // peak detectors
  // ----------------------------------------------------------------

  localparam int DW = $clog2(DECAY_CYCLES + 1);

  logic [DW-1:0]       decay_cnt;
  logic                decay_tick;
  logic [SAMPLE_W-1:0] err_peak;
  logic [SAMPLE_W-1:0] out_peak;

  assign decay_tick = (decay_cnt == DW'(DECAY_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || decay_tick) begin
      decay_cnt <= '0;
    end else begin
      decay_cnt <= decay_cnt + 1'b1;
    end
  end

  rpr_peak_track #(
    .W (SAMPLE_W)
  ) u_err_peak (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (rerr_sample_i),
    .valid_i  (rerr_valid_i),
    .decay_i  (decay_tick),
    .peak_o   (err_peak)
  );

  rpr_peak_track #(
    .W (SAMPLE_W)
  ) u_out_peak (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (rout_sample_o),
    .valid_i  (rout_valid_o),
    .decay_i  (decay_tick),
    .peak_o   (out_peak)
  );

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------

  logic [3:0] ev_now;
  logic [3:0] ev_prev;
  logic [3:0] ev_rise;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] next_irq_status;
  logic       irq_clr;
  logic       mask_wr;

  assign ev_now = {
    line_nonlinear_active_i,
    double_talk_flag_i,
    send_narrowband_flag_i,
    receive_narrowband_flag_i
  };
  assign ev_rise = ev_now & ~ev_prev;
  assign irq_clr = bus_rd & (bus_sel == RPR_SEL_IRQ_ST);
  assign mask_wr = bus_wr & sel_i[0] & (bus_sel == RPR_SEL_IRQ_MASK);

  // a new event wins over the read clear
  assign next_irq_status = (irq_status & ~{4{irq_clr}}) | ev_rise;
  assign irq_o = |(irq_status & irq_mask);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_prev    <= 4'h0;
      irq_status <= 4'h0;
    end else begin
      ev_prev    <= ev_now;
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= `RPR_IRQ_MASK_RESET;
    end else if (mask_wr) begin
      irq_mask <= dat_i[3:0];
    end
  end

  // ----------------------------------------------------------------
  // read data and acknowledge
  // ----------------------------------------------------------------

  rpr_byte_t rd_byte;

  assign rd_byte =
    (bus_sel == RPR_SEL_STATUS)   ? line_status :
    (bus_sel == RPR_SEL_ERR_LO)   ? err_peak[7:0] :
    (bus_sel == RPR_SEL_ERR_HI)   ? err_peak[15:8] :
    (bus_sel == RPR_SEL_GAIN)     ? receive_gain_setting :
    (bus_sel == RPR_SEL_OUT_LO)   ? out_peak[7:0] :
    (bus_sel == RPR_SEL_IRQ_ST)   ? {4'h0, irq_status} :
    (bus_sel == RPR_SEL_IRQ_MASK) ? {4'h0, irq_mask} :
    8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      if (bus_rd) begin
        dat_o <= {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_nbr_bit;
    1'b1 |=> line_status[`RPR_BIT_NBR] == $past(receive_narrowband_flag_i);
  endproperty
  a_nbr_bit: assert property (p_nbr_bit)
    else $error("status bit 0 does not follow receive narrowband");

  property p_nb_any;
    1'b1 |=> line_status[`RPR_BIT_NB] ==
             ($past(receive_narrowband_flag_i) | $past(send_narrowband_flag_i));
  endproperty
  a_nb_any: assert property (p_nb_any)
    else $error("status bit 1 is not the or of both narrowband flags");

  sequence s_dt_held;
    double_talk_flag_i [*2];
  endsequence

  property p_dt_bit;
    s_dt_held |=> line_status[`RPR_BIT_DT] && $past(line_status[`RPR_BIT_DT]);
  endproperty
  a_dt_bit: assert property (p_dt_bit)
    else $error("status bit 2 low while double talk held");

  property p_nlp_bit;
    1'b1 |=> line_status[`RPR_BIT_NLP] == $past(line_nonlinear_active_i)
             && line_status[7:4] == 4'h0;
  endproperty
  a_nlp_bit: assert property (p_nlp_bit)
    else $error("status bit 3 wrong or reserved bits set");

  property p_gain_write;
    gain_wr |=> receive_gain_setting ==
                {$past(receive_gain_setting[7:4]), $past(dat_i[3:0])};
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("gain code write not stored");

  property p_gain_hold;
    !gain_wr |=> receive_gain_setting == $past(receive_gain_setting);
  endproperty
  a_gain_hold: assert property (p_gain_hold)
    else $error("gain register changed without a write");

  sequence s_read_err_hi;
    bus_rd && bus_sel == RPR_SEL_ERR_HI;
  endsequence

  property p_err_hi_read;
    s_read_err_hi |=> ack_o && dat_o == {24'h000000, $past(err_peak[15:8])};
  endproperty
  a_err_hi_read: assert property (p_err_hi_read)
    else $error("error peak high byte read wrong");

  property p_out_lo_read;
    bus_rd && bus_sel == RPR_SEL_OUT_LO |=>
      ack_o && dat_o[7:0] == $past(out_peak[7:0]);
  endproperty
  a_out_lo_read: assert property (p_out_lo_read)
    else $error("output peak low byte read wrong");

  property p_status_read_clean;
    bus_rd && bus_sel == RPR_SEL_STATUS |=>
      irq_status == ($past(irq_status) | $past(ev_rise));
  endproperty
  a_status_read_clean: assert property (p_status_read_clean)
    else $error("status read disturbed other state");

  property p_err_lo_read;
    bus_rd && bus_sel == RPR_SEL_ERR_LO |=>
      ack_o && dat_o == {24'h000000, $past(err_peak[7:0])};
  endproperty
  a_err_lo_read: assert property (p_err_lo_read)
    else $error("error peak low byte read wrong");

  property p_gain_read;
    bus_rd && bus_sel == RPR_SEL_GAIN |=>
      ack_o && dat_o == {24'h000000, $past(receive_gain_setting)};
  endproperty
  a_gain_read: assert property (p_gain_read)
    else $error("gain register read wrong");

  sequence s_irq_event;
    ev_rise != 4'h0;
  endsequence

  property p_irq_set_wins;
    s_irq_event |=> (irq_status & $past(ev_rise)) == $past(ev_rise);
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins)
    else $error("flag event lost against a status read");

  property p_ack_single;
    ack_o |=> !ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("acknowledge held longer than one cycle");

endmodule : rpr_regs

// ### sim/rpr_host_model.sv
// wishbone master standing in for the host microcontroller
// assumes a classic single-cycle slave that answers with ack
`timescale 1ns/1ps

module rpr_host_model (
  // clock
  input  wire logic        clk_i,
  // wishbone master
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [9:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 10'h3FF;
    sel_o = 4'h0;
    dat_o = 32'hFFFFFFFF;
  end

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'b00};
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    adr_o <= ~{idx, 2'b00};
    dat_o <= ~d;
    @(posedge clk_i);
  endtask : xfer
endmodule : rpr_host_model

// ### sim/rpr_regs_tb.sv
// self-checking bench for the receive path register group
// assumes the host model drives the bus and the bench drives the rest
`timescale 1ns/1ps

module rpr_regs_tb;
  import rpr_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, rin_v, rerr_v, rout_v, irq;
  logic [9:0]  adr;
  logic [3:0]  sel, flg;
  logic [31:0] wdat, rdat;
  logic [15:0] rin, rerr, rout;
  int          errors = 0;
  int          compares = 0;
  int          cyc_cnt = 0;

  always #2.5 clk_i = ~clk_i;

  rpr_host_model host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

  rpr_regs #(.DECAY_CYCLES(1000000)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .receive_narrowband_flag_i(flg[0]), .send_narrowband_flag_i(flg[1]),
    .double_talk_flag_i(flg[2]), .line_nonlinear_active_i(flg[3]), .rin_sample_i(rin),
    .rin_valid_i(rin_v), .rerr_sample_i(rerr), .rerr_valid_i(rerr_v),
    .rout_sample_o(rout), .rout_valid_o(rout_v), .irq_o(irq));

  // ----------------------------------------------------------------
  // checks and helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic rd(input rpr_byte_t idx, input logic [31:0] exp);
    logic [31:0] q;
    host.xfer(1'b0, idx, 4'hF, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic wr(input rpr_byte_t idx, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, idx, s, d, q);
  endtask : wr

  task automatic send_rin(input logic [15:0] s, input logic [15:0] exp);
    @(posedge clk_i);
    rin   <= s;
    rin_v <= 1'b1;
    @(posedge clk_i);
    rin_v <= 1'b0;
    #1;
    chk({31'h0, rout_v}, 32'h1);
    chk({16'h0, rout}, {16'h0, exp});
  endtask : send_rin

  task automatic send_err(input logic [15:0] s);
    @(posedge clk_i);
    rerr   <= s;
    rerr_v <= 1'b1;
    @(posedge clk_i);
    rerr_v <= 1'b0;
  endtask : send_err

  function automatic logic [31:0] exp_status(input logic [3:0] f);
    return {28'h0, f[3], f[2], f[1] | f[0], f[0]};
  endfunction : exp_status

  function automatic logic [15:0] exp_sat(input logic [15:0] s);
    return s[15] ? 16'h8000 : 16'h7FFF;
  endfunction : exp_sat

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rpr_byte_t   ri [8];
    logic [31:0] rv [8];
    logic [15:0] s;
    logic [3:0]  f;
    logic [31:0] q;
    ri = '{8'h02, 8'h18, 8'h19, 8'h20, 8'h3A, 8'h40, 8'h41, 8'h7F};
    rv = '{32'h00, 32'h00, 32'h00, 32'h6D, 32'h00, 32'h00, 32'h00, 32'h00};
    flg = 4'h0;
    rin = 16'h0;
    rin_v = 1'b0;
    rerr = 16'h0;
    rerr_v = 1'b0;
    void'($urandom(50313));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd(ri[i], rv[i]);
    wr(8'h20, 4'h1, 32'h8);
    send_err(16'hFED4);
    send_err(16'h0100);
    rd(8'h18, 32'h2C);
    rd(8'h19, 32'h01);
    send_err(16'h8000);
    rd(8'h18, 32'hFF);
    rd(8'h19, 32'h7F);
    send_rin(16'h0234, 16'h0234);
    rd(8'h3A, 32'h34);
    // gain codes all read back
    for (int c = 0; c < 16; c++) begin
      wr(8'h20, 4'h1, 32'(c));
      rd(8'h20, {24'h0, 4'h6, 4'(c)});
    end
    wr(8'h20, 4'h0, 32'h5);
    rd(8'h20, 32'h6F);
    wr(8'h7F, 4'hF, 32'h5);
    rd(8'h7F, 32'h0);
    send_rin(16'h4000, exp_sat(16'h4000));
    send_rin(16'hC000, exp_sat(16'hC000));
    wr(8'h20, 4'h1, 32'h8);
    repeat (8) begin
      s = 16'($urandom);
      send_rin(s, s);
    end
    // status flags follow detectors
    repeat (12) begin
      f = 4'($urandom);
      @(posedge clk_i);
      flg <= f;
      repeat (2) @(posedge clk_i);
      rd(8'h02, exp_status(f));
      rd(8'h02, exp_status(f));
    end
    // interrupt masked then unmasked
    @(posedge clk_i);
    flg <= 4'h0;
    wr(8'h41, 4'h1, 32'h0);
    host.xfer(1'b0, 8'h40, 4'hF, 32'h0, q);
    rd(8'h40, 32'h0);
    flg <= 4'h4;
    repeat (3) @(posedge clk_i);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd(8'h40, 32'h4);
    rd(8'h40, 32'h0);
    flg <= 4'h0;
    wr(8'h41, 4'h1, 32'h4);
    flg <= 4'h4;
    repeat (3) @(posedge clk_i);
    #1;
    chk({31'h0, irq}, 32'h1);
    rd(8'h40, 32'h4);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd(8'h02, 32'h4);
    conclude();
  end
endmodule : rpr_regs_tb
